/* File: core/pwr_cmd_port.sv */
// I2C target port and command registers of the power-supply controller.
// Assumes an open-drain bus resolved outside; telemetry data and events
// come from logic on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module pwr_cmd_port
  import pwr_cmd_pkg::*;
#(
  parameter int unsigned GAP_CNT = GAP_CYCLES,
  parameter int unsigned IRQ_CNT = IRQ_CYCLES,
  parameter int unsigned VI_CNT  = VI_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Serial clock pin
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_b,
  // Serial data pin
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_b,
  // Telemetry read port
  output logic      [7:0]  telem_addr,
  input  wire logic [15:0] telem_data,
  // Device events
  input  wire logic        thermal_shutdown,
  input  wire logic        fault_irq_req,
  input  wire logic        vi_update_done,
  // Command register contents
  output logic      [7:0]  series_switch_control,
  output logic      [7:0]  output_bleeder_control,
  output logic      [7:0]  load_discharge_control,
  output logic      [7:0]  supply_latch_off,
  output logic      [7:0]  regulation_update_speed,
  // Decoded controls
  output logic             series_switch_enable,
  output logic             load_discharge,
  output logic             ctrl_reset_pulse,
  output logic             vi_update_ready,
  output logic             parity_error_pulse
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
  } st_e;
  st_e               state_reg;
  logic [1:0]        pins_s;
  logic              scl_q_reg;
  logic              sda_q_reg;
  logic [3:0]        bit_reg;
  logic [7:0]        sh_reg;
  logic [7:0]        tx_sh_reg;
  logic              rw_reg;
  logic              hi_reg;
  logic [1:0]        nbyte_reg;
  logic [7:0]        cmd_reg;
  logic [7:0]        d0_reg;
  logic [7:0]        end_reg;
  logic [CNT_W-1:0]  gap_reg;
  logic [CNT_W-1:0]  irq_cnt_reg;
  logic [CNT_W-1:0]  vi_cnt_reg;
  logic              irq_pend_reg;
  pin_sync u_sync (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .pin_in       ({scl_in, sda_in}),
    .pin_sync_out (pins_s)
  );
  wire scl_s    = pins_s[1];
  wire sda_s    = pins_s[0];
  wire scl_rise = scl_s & ~scl_q_reg;
  wire scl_fall = ~scl_s & scl_q_reg;
  wire start_c  = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  wire stop_c   = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  wire byte_done = scl_fall & (bit_reg == BITS_PER_BYTE);
  wire gap_ok   = (gap_reg == CNT_W'(GAP_CNT));
  wire irq_busy = (irq_cnt_reg != '0);
  // Commit decode at stop
  wire       cmd_par_ok = odd_par(cmd_reg);
  wire [6:0] base       = cmd_reg[6:0];
  wire       short_wr   = stop_c & (state_reg != ST_IDLE) & (nbyte_reg == BYTES_SHORT_WR);
  wire       wr_ok      = short_wr & cmd_par_ok;
  wire       d0_par_ok  = odd_par(d0_reg);
  wire       hit_sw     = wr_ok & (base == OFF_SERIES) & d0_par_ok;
  wire       hit_bl     = wr_ok & (base == OFF_BLEEDER);
  wire       hit_dis    = wr_ok & (base == OFF_DISCHARGE) & d0_par_ok;
  wire       hit_lat    = wr_ok & (base == OFF_LATCH_OFF);
  wire       hit_spd    = wr_ok & (base == OFF_SPEED);
  wire       prot_reg   = (base == OFF_SERIES) | (base == OFF_DISCHARGE);
  wire       par_bad    = short_wr & (~cmd_par_ok | (prot_reg & ~d0_par_ok));
  wire [1:0] sw_code    = d0_reg[1:0];
  wire [1:0] dis_act    = d0_reg[1:0];
  wire       dis_off    = d0_reg[3:2] == CODE_11;
  wire       dis_on     = ~dis_off & ((dis_act == CODE_11) | (dis_act == CODE_10));
  wire       rst_req    = (hit_sw & (sw_code == CODE_00)) | (hit_dis & dis_on);
  wire       addr_match = sh_reg[7:1] == TARGET_ADDR;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end
  // quiet time since the last stop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) gap_reg <= CNT_W'(GAP_CNT);
    else if (stop_c) gap_reg <= '0;
    else if (!gap_ok) gap_reg <= gap_reg + 1'b1;
  end
  // Transaction engine
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= ST_IDLE;
      bit_reg    <= '0;
      sh_reg     <= '0;
      tx_sh_reg  <= '0;
      rw_reg     <= DIR_WRITE;
      hi_reg     <= 1'b0;
      nbyte_reg  <= '0;
      cmd_reg    <= '0;
      d0_reg     <= '0;
      end_reg    <= '0;
      telem_addr <= '0;
      sda_oe_b   <= 1'b1;
    end else if (start_c && !irq_busy) begin
      bit_reg  <= '0;
      sda_oe_b <= 1'b1;
      if (state_reg == ST_IDLE || state_reg == ST_IGNORE) begin
        nbyte_reg <= '0;
        // too early after the last stop
        state_reg <= gap_ok ? ST_ADDR : ST_IGNORE;
      end else begin
        // repeated start keeps the gathered addresses
        state_reg <= ST_ADDR;
      end
    end else if (stop_c) begin
      state_reg <= ST_IDLE;
      sda_oe_b  <= 1'b1;
    end else begin
      case (state_reg)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            sh_reg  <= {sh_reg[6:0], sda_s};
            bit_reg <= bit_reg + 1'b1;
          end else if (byte_done && state_reg == ST_ADDR) begin
            bit_reg <= '0;
            if (addr_match) begin
              rw_reg    <= sh_reg[0];
              sda_oe_b  <= 1'b0;
              state_reg <= ST_ADDR_ACK;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end else if (byte_done) begin
            bit_reg <= '0;
            if (nbyte_reg == BYTES_RANGE_WR) begin
              state_reg <= ST_IGNORE;
            end else begin
              sda_oe_b  <= 1'b0;
              state_reg <= ST_RX_ACK;
              nbyte_reg <= nbyte_reg + 1'b1;
              case (nbyte_reg)
                2'h0:    cmd_reg <= sh_reg;
                2'h1:    d0_reg  <= sh_reg;
                default: begin
                  telem_addr <= d0_reg;
                  end_reg    <= sh_reg;
                end
              endcase
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg == DIR_READ) begin
              tx_sh_reg <= telem_data[7:0];
              sda_oe_b  <= telem_data[7];
              hi_reg    <= 1'b0;
              state_reg <= ST_TX;
            end else begin
              sda_oe_b  <= 1'b1;
              state_reg <= ST_RX;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            sda_oe_b  <= 1'b1;
            state_reg <= ST_RX;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_reg <= bit_reg + 1'b1;
          end else if (byte_done) begin
            sda_oe_b  <= 1'b1;
            bit_reg   <= '0;
            state_reg <= ST_TX_ACK;
          end else if (scl_fall) begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            sda_oe_b  <= tx_sh_reg[6];
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            sh_reg[0] <= sda_s;
            // step through the range while the host keeps acking
            if (!sda_s && hi_reg && telem_addr != end_reg) begin
              telem_addr <= telem_addr + 1'b1;
            end
          end else if (scl_fall) begin
            if (sh_reg[0]) begin
              state_reg <= ST_IGNORE;
            end else begin
              tx_sh_reg <= hi_reg ? telem_data[7:0] : telem_data[15:8];
              sda_oe_b  <= hi_reg ? telem_data[7] : telem_data[15];
              hi_reg    <= ~hi_reg;
              state_reg <= ST_TX;
            end
          end
        end
        ST_IGNORE: sda_oe_b <= 1'b1;
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end
  // Command registers and their effects
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      series_switch_control   <= RST_SERIES;
      output_bleeder_control  <= RST_BLEEDER;
      load_discharge_control  <= RST_DISCHARGE;
      supply_latch_off        <= RST_LATCH_OFF;
      regulation_update_speed <= RST_SPEED;
    end else begin
      if (hit_sw)  series_switch_control   <= d0_reg;
      if (hit_dis) load_discharge_control  <= d0_reg;
      if (hit_lat) supply_latch_off        <= d0_reg;
      if (hit_spd) regulation_update_speed <= d0_reg;
      // thermal shutdown overrides a bleeder write
      if (thermal_shutdown) begin
        output_bleeder_control <= RST_BLEEDER;
      end else if (hit_bl) begin
        output_bleeder_control <= d0_reg;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      series_switch_enable <= 1'b0;
      load_discharge       <= 1'b0;
      ctrl_reset_pulse     <= 1'b0;
      parity_error_pulse   <= 1'b0;
    end else begin
      ctrl_reset_pulse   <= rst_req;
      parity_error_pulse <= par_bad;
      if (hit_sw) begin
        series_switch_enable <= sw_code == CODE_11;
      end else if (hit_dis && dis_on && dis_act == CODE_11) begin
        series_switch_enable <= 1'b0;
      end
      if (hit_sw && sw_code == CODE_11) begin
        load_discharge <= 1'b0;
      end else if (hit_dis && dis_off) begin
        load_discharge <= 1'b0;
      end else if (hit_dis && dis_on) begin
        load_discharge <= 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vi_cnt_reg      <= '0;
      vi_update_ready <= 1'b1;
    end else begin
      if (vi_update_done) vi_cnt_reg <= CNT_W'(VI_CNT);
      else if (vi_cnt_reg != '0) vi_cnt_reg <= vi_cnt_reg - 1'b1;
      vi_update_ready <= regulation_update_speed[0] | (!vi_update_done && vi_cnt_reg <= 1);
    end
  end
  // interrupt pulse on the clock line, only while the bus is idle
  wire irq_go = irq_pend_reg & ~irq_busy & (state_reg == ST_IDLE) & scl_s & sda_s;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_pend_reg <= 1'b0;
      irq_cnt_reg  <= '0;
      scl_oe_b     <= 1'b1;
      scl_out      <= 1'b0;
      sda_out      <= 1'b0;
    end else begin
      // New request wins over the clear
      irq_pend_reg <= fault_irq_req | (irq_pend_reg & ~irq_go);
      if (irq_go) irq_cnt_reg <= CNT_W'(IRQ_CNT);
      else if (irq_busy) irq_cnt_reg <= irq_cnt_reg - 1'b1;
      // clock line driven only for the interrupt, never to stretch
      scl_oe_b     <= ~(irq_go | (irq_busy && irq_cnt_reg != 1));
      // Open drain: level stays low, the enables move the lines
      scl_out      <= 1'b0;
      sda_out      <= 1'b0;
    end
  end
endmodule // pwr_cmd_port
`default_nettype wire

/* File: core/pwr_cmd_pkg.sv */
// Constants for the power-supply command port: target address,
// command register offsets, reset values and timing figures.
// Assumes a 100 MHz core clock.
package pwr_cmd_pkg;

  localparam logic [6:0] TARGET_ADDR      = 7'h18;
  localparam logic       DIR_WRITE        = 1'b0;
  localparam logic       DIR_READ         = 1'b1;

  // Base offsets (parity bit removed)
  localparam logic [6:0] OFF_SERIES       = 7'h04;
  localparam logic [6:0] OFF_BLEEDER      = 7'h06;
  localparam logic [6:0] OFF_DISCHARGE    = 7'h08;
  localparam logic [6:0] OFF_LATCH_OFF    = 7'h0A;
  localparam logic [6:0] OFF_SPEED        = 7'h0C;

  localparam logic [7:0] RST_SERIES       = 8'h00;
  localparam logic [7:0] RST_BLEEDER      = 8'hD0;
  localparam logic [7:0] RST_DISCHARGE    = 8'h00;
  localparam logic [7:0] RST_LATCH_OFF    = 8'h00;
  localparam logic [7:0] RST_SPEED        = 8'h00;

  // Two-bit field codes
  localparam logic [1:0] CODE_00          = 2'h0;
  localparam logic [1:0] CODE_01          = 2'h1;
  localparam logic [1:0] CODE_10          = 2'h2;
  localparam logic [1:0] CODE_11          = 2'h3;

  // Bit counts per byte and bytes per write
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam logic [1:0] BYTES_SHORT_WR   = 2'h2;
  localparam logic [1:0] BYTES_RANGE_WR   = 2'h3;

  // Timing
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned GAP_US          = 150;
  localparam int unsigned IRQ_US          = 55;
  localparam int unsigned VI_LIMIT_MS     = 10;
  localparam int unsigned GAP_CYCLES      = GAP_US * CLK_MHZ;
  localparam int unsigned IRQ_CYCLES      = IRQ_US * CLK_MHZ;
  localparam int unsigned VI_CYCLES       = VI_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W           = 20;

  // Odd parity holds when the byte has an odd number of ones
  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ^b;
  endfunction

endpackage

/* File: core/pin_sync.sv */
// Two-flop synchroniser for the serial clock and data pins.
// Assumes idle-high open-drain lines; resets to high.
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Pins in, synchronised out
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_sync_out
);

  logic [1:0] meta_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg     <= 2'h3;
      pin_sync_out <= 2'h3;
    end else begin
      meta_reg     <= pin_in;
      pin_sync_out <= meta_reg;
    end
  end

endmodule // pin_sync
`default_nettype wire

/* File: verif/i2c_host_model.sv */
// Behavioural I2C controller that drives the command port's bus.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
  // Resolved bus levels
  input  wire logic scl,
  input  wire logic sda,
  // Drives, low pulls the line
  output logic      scl_d,
  output logic      sda_d
);
  initial begin
    scl_d = 1'b1;
    sda_d = 1'b1;
  end
  task automatic start();
    // Repeated start: the model itself holds the clock low
    if (scl_d) wait (scl === 1'b1);
    #60 sda_d = 1'b1;
    #20 scl_d = 1'b1;
    #40 sda_d = 1'b0;
    #40 scl_d = 1'b0;
  endtask
  task automatic stop();
    #20 sda_d = 1'b0;
    #20 scl_d = 1'b1;
    #40 sda_d = 1'b1;
    #40;
  endtask
  // Data set mid low phase, sampled late in high phase
  task automatic bit_io(input logic o, output logic i);
    #20 sda_d = o;
    #20 scl_d = 1'b1;
    #35 i = sda;
    #5 scl_d = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic x;
    for (int k = 7; k >= 0; k--) bit_io(b[k], x);
    bit_io(1'b1, x);
    ack = ~x;
  endtask
  // ack low byte, nack the last
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic x;
    for (int k = 7; k >= 0; k--) bit_io(1'b1, b[k]);
    bit_io(~ack, x);
  endtask
endmodule // i2c_host_model
`default_nettype wire

/* File: verif/pwr_cmd_port_chk.sv */
// Concurrent checks on the command port's pins and registers.
// Assumes it is bound onto pwr_cmd_port and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module pwr_cmd_port_chk #(
  parameter int unsigned GAP_CNT = 40,
  parameter int unsigned IRQ_CNT = 20,
  parameter int unsigned VI_CNT  = 50
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // Pins and events
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       scl_oe_b,
  input wire logic       thermal_shutdown,
  input wire logic       vi_update_done,
  // Registers and controls
  input wire logic [7:0] series_switch_control,
  input wire logic [7:0] output_bleeder_control,
  input wire logic [7:0] load_discharge_control,
  input wire logic [7:0] supply_latch_off,
  input wire logic [7:0] regulation_update_speed,
  input wire logic       series_switch_enable,
  input wire logic       load_discharge,
  input wire logic       ctrl_reset_pulse,
  input wire logic       vi_update_ready,
  input wire logic       parity_error_pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] low_cnt;
  // Length of the current pull on SCL
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) low_cnt <= '0;
    else if (scl_oe_b) low_cnt <= '0;
    else low_cnt <= low_cnt + 16'h0001;
  end
  AST_THERM_CLR: assert property (
    thermal_shutdown |=> output_bleeder_control == 8'hD0) else $error("bleeder kept");
  AST_SW_ON: assert property (
    $changed(series_switch_control) && series_switch_control[1:0] == 2'b11
    |-> ##[0:1] series_switch_enable) else $error("switch not on");
  AST_SW_OFF: assert property (
    $changed(series_switch_control) && series_switch_control[1:0] == 2'b01
    |-> ##[0:1] !series_switch_enable) else $error("switch not off");
  AST_SW_RST: assert property (
    $changed(series_switch_control) && series_switch_control[1:0] == 2'b00
    |-> ##[0:2] ctrl_reset_pulse) else $error("no reset pulse");
  AST_DIS_OFF: assert property (
    $changed(load_discharge_control) && load_discharge_control[3:2] == 2'b11
    |-> ##[0:1] !load_discharge) else $error("discharge not off");
  AST_DIS_ON: assert property (
    $changed(load_discharge_control) && load_discharge_control[3:2] != 2'b11
    && load_discharge_control[1] |-> ##[0:1] load_discharge) else $error("discharge off");
  AST_IRQ_LEN: assert property (
    $rose(scl_oe_b) |-> low_cnt == IRQ_CNT) else $error("interrupt pulse length");
  AST_IRQ_IDLE: assert property (
    $fell(scl_oe_b) |-> $past(scl_in) && $past(sda_in)) else $error("clock held in transfer");
  AST_VI_SLOW: assert property (
    vi_update_done && !regulation_update_speed[0] |=> !vi_update_ready [*8])
    else $error("update spacing missing");
  AST_VI_FAST: assert property (
    vi_update_done && regulation_update_speed[0] |=> vi_update_ready)
    else $error("update limit applied");
  AST_PAR_DROP: assert property (
    parity_error_pulse |-> $stable(series_switch_control) && $stable(load_discharge_control)
    && $stable(supply_latch_off)) else $error("bad parity write stored");
endmodule // pwr_cmd_port_chk
bind pwr_cmd_port pwr_cmd_port_chk #(
  .GAP_CNT(GAP_CNT), .IRQ_CNT(IRQ_CNT), .VI_CNT(VI_CNT)
) chk_u (
  .ref_clk, .rst_b, .scl_in, .sda_in, .scl_oe_b, .thermal_shutdown, .vi_update_done,
  .series_switch_control, .output_bleeder_control, .load_discharge_control,
  .supply_latch_off, .regulation_update_speed, .series_switch_enable, .load_discharge,
  .ctrl_reset_pulse, .vi_update_ready, .parity_error_pulse
);
`default_nettype wire

/* File: verif/pwr_cmd_port_tb_top.sv */
// Self-checking bench for the power-supply command port.
// Assumes the host model drives the bus; pull-ups are resolved here.
`timescale 1ns/10ps
`default_nettype none
module pwr_cmd_port_tb_top;
  import pwr_cmd_pkg::*;
  // Shortened counts keep the run brief
  localparam int unsigned GAP = 40;
  localparam int unsigned IRQ = 20;
  localparam int unsigned VI  = 50;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        scl, sda, scl_d, sda_d, scl_out, scl_oe_b, sda_out, sda_oe_b;
  logic        thermal = 1'b0, irq_req = 1'b0, vi_done = 1'b0;
  logic        sw_en, dis_en, rst_p, vi_rdy, par_p;
  logic [7:0]  telem_addr, sw_q, bl_q, dis_q, lat_q, spd_q;
  logic [15:0] telem_data;
  logic [39:0] regs;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_par = 0;
  function automatic logic [7:0] op(input logic [6:0] b);
    return {~^b, b};
  endfunction
  function automatic logic [15:0] tw(input logic [7:0] a);
    return {a ^ 8'hA5, ~a};
  endfunction
  always #5 ref_clk = ~ref_clk;
  assign scl = scl_d & (scl_oe_b | scl_out);
  assign sda = sda_d & (sda_oe_b | sda_out);
  assign telem_data = tw(telem_addr);
  assign regs = {spd_q, lat_q, dis_q, bl_q, sw_q};
  // Parity error pulses seen on the output
  always @(posedge ref_clk) if (par_p === 1'b1) n_par++;
  pwr_cmd_port #(.GAP_CNT(GAP), .IRQ_CNT(IRQ), .VI_CNT(VI)) dut_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_b(scl_oe_b), .sda_in(sda), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
    .telem_addr(telem_addr), .telem_data(telem_data), .thermal_shutdown(thermal),
    .fault_irq_req(irq_req), .vi_update_done(vi_done),
    .series_switch_control(sw_q), .output_bleeder_control(bl_q),
    .load_discharge_control(dis_q), .supply_latch_off(lat_q),
    .regulation_update_speed(spd_q), .series_switch_enable(sw_en),
    .load_discharge(dis_en), .ctrl_reset_pulse(rst_p), .vi_update_ready(vi_rdy),
    .parity_error_pulse(par_p)
  );
  i2c_host_model host_u (.scl(scl), .sda(sda), .scl_d(scl_d), .sda_d(sda_d));
  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [39:0] e, input logic [39:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    @(posedge ref_clk) #1 s = 1'b1;
    @(posedge ref_clk) #1 s = 1'b0;
    @(posedge ref_clk) #1;
  endtask
  task automatic wr(input int gap, input logic [6:0] ad, input logic [7:0] c, d,
                    input logic [2:0] ea);
    logic a0, a1, a2;
    repeat (gap) @(posedge ref_clk);
    #1 host_u.start();
    host_u.wr_byte({ad, DIR_WRITE}, a0);
    host_u.wr_byte(c, a1);
    host_u.wr_byte(d, a2);
    host_u.stop();
    repeat (4) @(posedge ref_clk);
    #1 chk("ack", {37'h0, ea}, {37'h0, a0, a1, a2});
  endtask
  task automatic rd(input logic [7:0] s, e);
    logic a;
    logic [7:0] lo, hi;
    logic [15:0] w;
    repeat (GAP + 10) @(posedge ref_clk);
    #1 host_u.start();
    host_u.wr_byte({TARGET_ADDR, DIR_WRITE}, a);
    host_u.wr_byte(op(OFF_SERIES), a);
    host_u.wr_byte(s, a);
    host_u.wr_byte(e, a);
    host_u.start();
    host_u.wr_byte({TARGET_ADDR, DIR_READ}, a);
    chk("read ack", 40'h1, {39'h0, a});
    for (int k = s; k <= e; k++) begin
      w = tw(k[7:0]);
      host_u.rd_byte(1'b1, lo);
      host_u.rd_byte(k != e, hi);
      chk("low byte", {32'h0, w[7:0]}, {32'h0, lo});
      chk("high byte", {32'h0, w[15:8]}, {32'h0, hi});
    end
    host_u.stop();
  endtask
  initial begin
    logic [7:0] d;
    logic [6:0] offs [5];
    logic [1:0] sc [3];
    logic [1:0] bc [3];
    logic [3:0] dc [3];
    int j, cnt;
    j = $urandom(32'h2175);
    offs = '{OFF_SERIES, OFF_BLEEDER, OFF_DISCHARGE, OFF_LATCH_OFF, OFF_SPEED};
    sc = '{CODE_11, CODE_01, CODE_00};
    bc = '{CODE_00, CODE_01, CODE_11};
    dc = '{4'hC, 4'h3, 4'h2};
    repeat (3) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk("regs", {RST_SPEED, RST_LATCH_OFF, RST_DISCHARGE, RST_BLEEDER, RST_SERIES}, regs);
    for (int i = 0; i < 20; i++) begin
      j = int'($urandom % 5);
      d = 8'($urandom);
      if (j == 0 || j == 2) d = op(d[6:0]);
      wr(GAP + 10, TARGET_ADDR, op(offs[j]), d, 3'b111);
      chk("reg", {32'h0, d}, {32'h0, regs[j*8 +: 8]});
    end
    for (int k = 0; k < 3; k++) begin
      wr(GAP + 10, TARGET_ADDR, op(OFF_SERIES), op({5'h0, sc[k]}), 3'b111);
      chk("switch", {39'h0, sc[k] == CODE_11}, {39'h0, sw_en});
      wr(GAP + 10, TARGET_ADDR, op(OFF_DISCHARGE), op({3'h0, dc[k]}), 3'b111);
      chk("discharge", {39'h0, dc[k][3:2] != CODE_11}, {39'h0, dis_en});
      wr(GAP + 10, TARGET_ADDR, op(OFF_BLEEDER), {6'h34, bc[k]}, 3'b111);
      chk("bleeder", {32'h0, 6'h34, bc[k]}, {32'h0, bl_q});
    end
    wr(GAP + 10, TARGET_ADDR, op(OFF_LATCH_OFF), 8'h01, 3'b111);
    wr(GAP + 10, TARGET_ADDR ^ 7'h01, op(OFF_LATCH_OFF), 8'h00, 3'b000);
    wr(2, TARGET_ADDR, op(OFF_LATCH_OFF), 8'h00, 3'b000);
    wr(GAP + 10, TARGET_ADDR, op(OFF_LATCH_OFF) ^ 8'h80, 8'h00, 3'b111);
    chk("latch", 40'h01, {32'h0, lat_q});
    wr(GAP + 10, TARGET_ADDR, op(OFF_SERIES), op(7'h03) ^ 8'h80, 3'b111);
    chk("series", {32'h0, op(7'h00)}, {32'h0, sw_q});
    chk("parity errors", 40'h2, 40'(n_par));
    rd(8'h10, 8'h12);
    pulse(thermal);
    chk("bleeder", {32'h0, RST_BLEEDER}, {32'h0, bl_q});
    cnt = 0;
    fork
      pulse(irq_req);
      repeat (IRQ + 20) @(posedge ref_clk) #1 cnt += int'(scl_oe_b === 1'b0);
    join
    chk("irq length", {8'h0, IRQ}, {8'h0, cnt});
    for (int s = 0; s < 2; s++) begin
      wr(GAP + 10, TARGET_ADDR, op(OFF_SPEED), 8'(s), 3'b111);
      pulse(vi_done);
      chk("update ready", 40'(s), {39'h0, vi_rdy});
      repeat (VI + 3) @(posedge ref_clk);
      #1 chk("update ready", 40'h1, {39'h0, vi_rdy});
    end
    summarize();
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    summarize();
  end
endmodule // pwr_cmd_port_tb_top
`default_nettype wire
